// ### rtl/spi_pointer_interp.sv
// receive payload pointer interpreter with alarm latches
`default_nettype none
// Summary of operation
// - normal flag, I bits inverted is increment
// - normal flag, D bits inverted is decrement
// - normal needs 3-of-4 flag, value to 782
// - new data needs 3-of-4 flag, value to 782
// - SS bits checked in SDH, ignored SONET
// - other pairs carry concatenation or AIS
// - no justification three frames after adjustment
// - SONET increment needs eight matching bits
// - SONET decrement needs eight matching bits
// - SDH increment: three I, two D inverted
// - SDH decrement: three D, two I inverted
// - SDH both majorities inverted: no action
// - three states: normal, pointer loss, alarm
// - new data pointer adopted at once in normal state
// - three equal normal pointers enter normal
// - three AIS pointers enter alarm state
// - eight invalid pointers enter pointer loss
// - valid justification steps pointer at once
// - in alarm state only AIS valid
// - normal state: equal pointer counts valid
// - alarm change sets latch flag, pending
// - pointer loss change sets latch, pending
// - flag 15:12, SS 11:10, value below
// - SONET checks 192 pairs, SDH 64
// - mode input selects SONET or SDH
module spi_pointer_interp (
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic        sdh_mode,
    input  wire logic        ptr_valid,
    input  wire logic [7:0]  ptr_index,
    input  wire logic [15:0] ptr_word,
    input  wire logic        alarm_flag_read,
    input  wire logic        pending_read,
    input  wire logic        alarm_indication_irq_a_mask,
    input  wire logic        alarm_indication_irq_b_mask,
    input  wire logic        pointer_loss_irq_a_mask,
    input  wire logic        pointer_loss_irq_b_mask,
    output logic [9:0]       pointer_value,
    output logic             normal_state,
    output logic             pointer_loss_state,
    output logic             alarm_state,
    output logic             pointer_update,
    output logic             path_alarm_indication_flag,
    output logic             path_pointer_loss_flag,
    output logic             path_alarm_indication_pending,
    output logic             path_pointer_loss_pending,
    output logic             interrupt_out_a,
    output logic             interrupt_out_b
);
    spi_pkg::spi_state_e state_q, state_d;
    logic [9:0] ptr_q, ptr_d;
    logic [9:0] cls_val_q, last_val_q;
    logic       cls_normal_state_q, cls_ndf_q, cls_ais_q, cls_inc_q, cls_dec_q;
    logic       ci_bad_q;
    logic [1:0] normal_state_cnt_q, normal_state_cnt_d;
    logic [1:0] ais_cnt_q, ais_cnt_d;
    logic [3:0] inv_cnt_q, inv_cnt_d;
    logic [1:0] hold_q, hold_d;
    logic       upd_q;
    logic       ais_flag_q, lop_flag_q, ais_pend_q, lop_pend_q;

    wire logic c_normal_state;
    wire logic c_ndf;
    wire logic c_ais;
    wire logic c_inc;
    wire logic c_dec;
    wire logic c_ci_ok;

    // typed against the accepted value, which only moves at frame commit
    spi_classify u_classify (
        .word      (ptr_word),
        .cur_value (ptr_q),
        .sdh_mode  (sdh_mode),
        .is_normal_state   (c_normal_state),
        .is_ndf    (c_ndf),
        .is_ais    (c_ais),
        .is_inc    (c_inc),
        .is_dec    (c_dec),
        .ci_ok     (c_ci_ok)
    );

    // frame position decode
    wire logic [7:0] last_idx = sdh_mode ? spi_pkg::SDH_LAST : spi_pkg::SONET_LAST;
    wire logic examine  = ptr_valid && (ptr_index <= last_idx);
    wire logic primary  = examine && (ptr_index == 8'h00);
    wire logic commit   = examine && (ptr_index == last_idx);
    wire logic ci_beat  = examine && (ptr_index != 8'h00) && !c_ci_ok;

    // frame verdict, a bad concatenation pair spoils the whole frame
    wire logic f_bad  = ci_bad_q || ci_beat;
    wire logic f_normal_state = cls_normal_state_q && !f_bad;
    wire logic f_ndf  = cls_ndf_q && !f_bad;
    wire logic f_ais  = cls_ais_q && !f_bad;
    wire logic f_eq   = f_normal_state && (cls_val_q == ptr_q);
    wire logic hold_0 = hold_q == 2'h0;
    wire logic in_normal_state = state_q == spi_pkg::ST_NORMAL_STATE;
    wire logic in_ais  = state_q == spi_pkg::ST_AIS;
    wire logic in_lop  = state_q == spi_pkg::ST_LOP;

    // inc wins if both majorities look true, which no legal word produces
    wire logic take_ndf = in_normal_state && f_ndf;
    wire logic take_inc = in_normal_state && hold_0 && cls_inc_q && !f_bad;
    wire logic take_dec = in_normal_state && hold_0 && cls_dec_q && !cls_inc_q && !f_bad;
    wire logic adjust   = take_ndf || take_inc || take_dec;

    // a pointer only builds persistence if it repeats the previous frame's value
    wire logic normal_state_same = f_normal_state && (cls_val_q == last_val_q) && (normal_state_cnt_q != 2'h0);
    wire logic go_normal_state   = normal_state_cnt_d == spi_pkg::NORMAL_STATE_PERSIST;
    wire logic go_ais    = !go_normal_state && !in_ais && (ais_cnt_d == spi_pkg::AIS_PERSIST);
    // in alarm state only an AIS pointer keeps the loss counter clear
    wire logic valid_frm = in_ais ? f_ais : (adjust || f_eq || go_normal_state);
    wire logic go_lop    = !go_normal_state && !go_ais && !in_lop && (inv_cnt_d == spi_pkg::LOP_PERSIST);

    // steps wrap inside the legal range so a justification never leaves it
    wire logic [9:0] ptr_inc = (ptr_q == spi_pkg::PTR_MAX) ? 10'h000 : ptr_q + 10'h001;
    wire logic [9:0] ptr_dec = (ptr_q == 10'h000) ? spi_pkg::PTR_MAX : ptr_q - 10'h001;

    always_comb begin
        normal_state_cnt_d = 2'h0;
        if (f_normal_state && normal_state_same) begin
            normal_state_cnt_d = (normal_state_cnt_q == spi_pkg::NORMAL_STATE_PERSIST) ? normal_state_cnt_q : normal_state_cnt_q + 2'h1;
        end else if (f_normal_state) begin
            normal_state_cnt_d = 2'h1;
        end
        ais_cnt_d = 2'h0;
        if (f_ais) begin
            ais_cnt_d = (ais_cnt_q == spi_pkg::AIS_PERSIST) ? ais_cnt_q : ais_cnt_q + 2'h1;
        end
        inv_cnt_d = 4'h0;
        if (!in_lop && !valid_frm) begin
            inv_cnt_d = (inv_cnt_q == spi_pkg::LOP_PERSIST) ? inv_cnt_q : inv_cnt_q + 4'h1;
        end
        // hold counts frames, not cycles: it only moves at commit
        hold_d = hold_0 ? 2'h0 : hold_q - 2'h1;
        if (adjust) begin
            hold_d = spi_pkg::JUST_HOLD;
        end
    end

    always_comb begin
        state_d = state_q;
        ptr_d   = ptr_q;
        if (go_normal_state) begin
            state_d = spi_pkg::ST_NORMAL_STATE;
            ptr_d   = cls_val_q;
        end else if (go_ais) begin
            state_d = spi_pkg::ST_AIS;
        end else if (go_lop) begin
            state_d = spi_pkg::ST_LOP;
        end else if (take_ndf) begin
            ptr_d = cls_val_q;
        end else if (take_inc) begin
            ptr_d = ptr_inc;
        end else if (take_dec) begin
            ptr_d = ptr_dec;
        end
        case (state_d)
            spi_pkg::ST_NORMAL_STATE, spi_pkg::ST_LOP, spi_pkg::ST_AIS: ;
            default: state_d = spi_pkg::ST_LOP;
        endcase
    end

    wire logic ais_chg = commit && ((state_d == spi_pkg::ST_AIS) != in_ais);
    wire logic lop_chg = commit && ((state_d == spi_pkg::ST_LOP) != in_lop);

    // primary pointer capture and concatenation check
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            cls_val_q  <= 10'h000;
            cls_normal_state_q <= 1'b0;
            cls_ndf_q  <= 1'b0;
            cls_ais_q  <= 1'b0;
            cls_inc_q  <= 1'b0;
            cls_dec_q  <= 1'b0;
            ci_bad_q   <= 1'b0;
        end else if (primary) begin
            cls_val_q  <= ptr_word[spi_pkg::VAL_MSB:0];
            cls_normal_state_q <= c_normal_state;
            cls_ndf_q  <= c_ndf;
            cls_ais_q  <= c_ais;
            cls_inc_q  <= c_inc;
            cls_dec_q  <= c_dec;
            ci_bad_q   <= 1'b0;
        end else if (ci_beat) begin
            ci_bad_q <= 1'b1;
        end
    end

    // per-frame state, counters and accepted value
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_q    <= spi_pkg::ST_LOP;
            ptr_q      <= spi_pkg::PTR_RESET;
            last_val_q <= 10'h000;
            normal_state_cnt_q <= 2'h0;
            ais_cnt_q  <= 2'h0;
            inv_cnt_q  <= 4'h0;
            hold_q     <= 2'h0;
        end else if (commit) begin
            state_q    <= state_d;
            ptr_q      <= ptr_d;
            last_val_q <= cls_val_q;
            normal_state_cnt_q <= normal_state_cnt_d;
            ais_cnt_q  <= ais_cnt_d;
            // a count saturated on the way into alarm must not carry over
            inv_cnt_q  <= go_ais ? 4'h0 : inv_cnt_d;
            hold_q     <= hold_d;
        end
    end

    // latch-high flags: a read returns the event, the next read the status
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            upd_q      <= 1'b0;
            ais_flag_q <= 1'b0;
            lop_flag_q <= 1'b0;
            ais_pend_q <= 1'b0;
            lop_pend_q <= 1'b0;
        end else begin
            upd_q <= commit;
            if (ais_chg) begin
                ais_flag_q <= 1'b1;
            end else if (alarm_flag_read) begin
                ais_flag_q <= in_ais;
            end
            if (lop_chg) begin
                lop_flag_q <= 1'b1;
            end else if (alarm_flag_read) begin
                lop_flag_q <= in_lop;
            end
            // a change in the read cycle wins over the clear
            if (ais_chg) begin
                ais_pend_q <= 1'b1;
            end else if (pending_read) begin
                ais_pend_q <= 1'b0;
            end
            if (lop_chg) begin
                lop_pend_q <= 1'b1;
            end else if (pending_read) begin
                lop_pend_q <= 1'b0;
            end
        end
    end

    assign pointer_value                 = ptr_q;
    assign normal_state                  = in_normal_state;
    assign pointer_loss_state            = in_lop;
    assign alarm_state                   = in_ais;
    assign pointer_update                = upd_q;
    assign path_alarm_indication_flag    = ais_flag_q;
    assign path_pointer_loss_flag        = lop_flag_q;
    assign path_alarm_indication_pending = ais_pend_q;
    assign path_pointer_loss_pending     = lop_pend_q;
    assign interrupt_out_a = (ais_pend_q && alarm_indication_irq_a_mask)
                          || (lop_pend_q && pointer_loss_irq_a_mask);
    assign interrupt_out_b = (ais_pend_q && alarm_indication_irq_b_mask)
                          || (lop_pend_q && pointer_loss_irq_b_mask);

    // all checks live in the one clock domain and pause during reset
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    a_state_onehot: assert property ($onehot(state_q))
        else $error("state is not one-hot");
    a_ndf_adopt: assert property (commit && in_normal_state && f_ndf && !go_normal_state && !go_ais && !go_lop
        |=> pointer_value == $past(cls_val_q) && normal_state)
        else $error("new data pointer not adopted");
    a_normal_state_three: assert property ($rose(normal_state)
        |-> $past(normal_state_cnt_q) == 2'h2 && $past(cls_normal_state_q) && $past(cls_val_q) == pointer_value)
        else $error("normal entered without three equal pointers");
    a_ais_three: assert property ($rose(alarm_state) |-> $past(ais_cnt_q) == 2'h2 && $past(f_ais))
        else $error("alarm entered without three AIS pointers");
    a_lop_eight: assert property ($rose(pointer_loss_state) |-> $past(inv_cnt_q) == 4'h7)
        else $error("pointer loss entered without eight invalid frames");
    a_hold_block: assert property (commit && hold_q != 2'h0 && in_normal_state && !f_ndf && !go_normal_state
        |=> $stable(pointer_value))
        else $error("justification taken inside hold window");
    a_inc_step: assert property (commit && take_inc && !go_normal_state && !go_ais && !go_lop
        |=> pointer_value == (($past(pointer_value) == spi_pkg::PTR_MAX) ? 10'h000
                              : $past(pointer_value) + 10'h001))
        else $error("increment not applied by one");
    a_sdh_ss_gate: assert property (primary && sdh_mode
        && ptr_word[spi_pkg::SS_MSB:spi_pkg::SS_LSB] != spi_pkg::SDH_SS |-> !c_normal_state && !c_ndf)
        else $error("SS mismatch accepted in SDH mode");
    a_ais_pending: assert property (ais_chg |=> path_alarm_indication_pending
        && path_alarm_indication_flag ##1 (path_alarm_indication_flag || $past(alarm_flag_read)))
        else $error("alarm change not latched");
    a_lop_pending: assert property (lop_chg |=> path_pointer_loss_pending && path_pointer_loss_flag)
        else $error("pointer loss change not latched");
    a_update_once: assert property (pointer_update |=> !pointer_update)
        else $error("update strobe longer than one cycle");
    a_commit_update: assert property (commit |=> pointer_update)
        else $error("no update strobe after commit");
    a_state_outputs: assert property ($onehot({normal_state, pointer_loss_state, alarm_state}))
        else $error("state outputs not one-hot");

    // justification and hold window
    a_dec_step: assert property (commit && take_dec && !go_normal_state && !go_ais && !go_lop
        |=> pointer_value == (($past(pointer_value) == 10'h000) ? spi_pkg::PTR_MAX
                              : $past(pointer_value) - 10'h001))
        else $error("decrement not applied by one");
    a_hold_load: assert property (commit && adjust |=> hold_q == spi_pkg::JUST_HOLD)
        else $error("hold window not loaded");
    a_pointer_hold: assert property (commit && !in_normal_state && !go_normal_state |=> $stable(pointer_value))
        else $error("pointer moved outside normal state");

    // frame validity and loss counting
    a_ci_spoil: assert property (commit && f_bad |=> $stable(pointer_value))
        else $error("frame with bad concatenation acted on");
    a_tail_ignored: assert property (ptr_valid && ptr_index > last_idx |=> $stable(pointer_value) && $stable(state_q))
        else $error("pair beyond last index acted on");
    a_ais_valid: assert property (commit && in_ais && f_ais |=> inv_cnt_q == 4'h0)
        else $error("AIS pointer counted invalid in alarm state");
    a_ais_fresh: assert property (commit && go_ais |=> inv_cnt_q == 4'h0)
        else $error("loss count carried into alarm state");
    a_lop_idle: assert property (commit && in_lop |=> inv_cnt_q == 4'h0)
        else $error("loss count running in pointer loss");

    // flags and pending bits
    a_ais_status: assert property (alarm_flag_read && !ais_chg |=> path_alarm_indication_flag == $past(in_ais))
        else $error("alarm flag not showing status after read");
    a_lop_status: assert property (alarm_flag_read && !lop_chg |=> path_pointer_loss_flag == $past(in_lop))
        else $error("loss flag not showing status after read");
    a_ais_sticky: assert property (path_alarm_indication_pending && !pending_read |=> path_alarm_indication_pending)
        else $error("alarm pending dropped without read");
    a_lop_sticky: assert property (path_pointer_loss_pending && !pending_read |=> path_pointer_loss_pending)
        else $error("loss pending dropped without read");

    // scenarios worth seeing in a run
    c_reach_ais: cover property ($rose(alarm_state));
    c_reach_normal_state: cover property ($rose(normal_state));
    c_take_inc: cover property (commit && take_inc);
    c_take_dec: cover property (commit && take_dec);
    c_reach_lop: cover property ($rose(pointer_loss_state));
endmodule : spi_pointer_interp
`default_nettype wire

// ### rtl/spi_pkg.sv
// constants and types shared by the pointer interpreter files
`default_nettype none
package spi_pkg;
    // pointer word fields
    localparam int unsigned FLAG_MSB = 15;
    localparam int unsigned FLAG_LSB = 12;
    localparam int unsigned SS_MSB   = 11;
    localparam int unsigned SS_LSB   = 10;
    localparam int unsigned VAL_MSB  = 9;
    // flag and value patterns
    localparam logic [3:0]  NORMAL_STATE_FLAG = 4'h6;
    localparam logic [3:0]  NDF_FLAG  = 4'h9;
    localparam logic [1:0]  SDH_SS    = 2'h2;
    localparam logic [9:0]  PTR_MAX   = 10'h30e;
    localparam logic [9:0]  CI_VALUE  = 10'h3ff;
    localparam logic [15:0] AIS_WORD  = 16'hffff;
    localparam logic [9:0]  I_MASK    = 10'h2aa;
    localparam logic [9:0]  D_MASK    = 10'h155;
    // majority thresholds
    localparam logic [2:0]  FLAG_MAX_MISS  = 3'h1;
    localparam logic [3:0]  SONET_MAX_MISS = 4'h2;
    localparam logic [3:0]  SDH_MIN_INV    = 4'h3;
    localparam logic [3:0]  SDH_MAX_OTHER  = 4'h2;
    // last examined byte pair index per mode
    localparam logic [7:0]  SONET_LAST = 8'hbf;
    localparam logic [7:0]  SDH_LAST   = 8'h3f;
    // persistence counts, in frames
    localparam logic [1:0]  NORMAL_STATE_PERSIST = 2'h3;
    localparam logic [1:0]  AIS_PERSIST  = 2'h3;
    localparam logic [3:0]  LOP_PERSIST  = 4'h8;
    localparam logic [1:0]  JUST_HOLD    = 2'h3;
    // reset values
    localparam logic [9:0]  PTR_RESET    = 10'h000;

    typedef enum logic [2:0] {
        ST_NORMAL_STATE = 3'b001,
        ST_LOP  = 3'b010,
        ST_AIS  = 3'b100
    } spi_state_e;
endpackage : spi_pkg
`default_nettype wire

// ### rtl/spi_classify.sv
// combinational typing of one received pointer word
`default_nettype none
module spi_classify (
    input  wire logic [15:0] word,
    input  wire logic [9:0]  cur_value,
    input  wire logic        sdh_mode,
    output logic             is_normal_state,
    output logic             is_ndf,
    output logic             is_ais,
    output logic             is_inc,
    output logic             is_dec,
    output logic             ci_ok
);
    function automatic logic [3:0] ones10(input logic [9:0] v);
        logic [3:0] n;
        n = 4'h0;
        for (int k = 0; k < 10; k++) begin
            n = n + {3'h0, v[k]};
        end
        return n;
    endfunction : ones10

    function automatic logic [2:0] ones4(input logic [3:0] v);
        return {2'h0, v[0]} + {2'h0, v[1]} + {2'h0, v[2]} + {2'h0, v[3]};
    endfunction : ones4

    wire logic [3:0] flag  = word[spi_pkg::FLAG_MSB:spi_pkg::FLAG_LSB];
    wire logic [1:0] ss    = word[spi_pkg::SS_MSB:spi_pkg::SS_LSB];
    wire logic [9:0] value = word[spi_pkg::VAL_MSB:0];
    wire logic [9:0] diff  = value ^ cur_value;

    wire logic flag_normal_state = ones4(flag ^ spi_pkg::NORMAL_STATE_FLAG) <= spi_pkg::FLAG_MAX_MISS;
    wire logic flag_ndf  = ones4(flag ^ spi_pkg::NDF_FLAG) <= spi_pkg::FLAG_MAX_MISS;
    wire logic ss_ok     = !sdh_mode || (ss == spi_pkg::SDH_SS);
    wire logic in_range  = value <= spi_pkg::PTR_MAX;

    // 8 of 10 matching means at most two bits off the expected pattern
    wire logic [3:0] inc_miss = ones10(diff ^ spi_pkg::I_MASK);
    wire logic [3:0] dec_miss = ones10(diff ^ spi_pkg::D_MASK);
    wire logic [3:0] inv_i    = ones10(diff & spi_pkg::I_MASK);
    wire logic [3:0] inv_d    = ones10(diff & spi_pkg::D_MASK);

    wire logic sonet_inc = inc_miss <= spi_pkg::SONET_MAX_MISS;
    wire logic sonet_dec = dec_miss <= spi_pkg::SONET_MAX_MISS;
    // both majorities set leaves neither condition true
    wire logic sdh_inc = inv_i >= spi_pkg::SDH_MIN_INV && inv_d <= spi_pkg::SDH_MAX_OTHER;
    wire logic sdh_dec = inv_d >= spi_pkg::SDH_MIN_INV && inv_i <= spi_pkg::SDH_MAX_OTHER;

    assign is_normal_state = flag_normal_state && ss_ok && in_range;
    assign is_ndf  = flag_ndf && ss_ok && in_range;
    assign is_ais  = word == spi_pkg::AIS_WORD;
    assign is_inc  = flag_normal_state && ss_ok && (sdh_mode ? sdh_inc : sonet_inc);
    assign is_dec  = flag_normal_state && ss_ok && (sdh_mode ? sdh_dec : sonet_dec);
    assign ci_ok   = is_ais || (flag_normal_state && ss_ok && value == spi_pkg::CI_VALUE);
endmodule : spi_classify
`default_nettype wire

// ### testbench/spi_line_src.sv
// far-end line source: sends the pointer byte pairs of one frame per call
`default_nettype none
module spi_line_src (
    input  wire logic        clk_sys,
    output logic             ptr_valid,
    output logic [7:0]       ptr_index,
    output logic [15:0]      ptr_word
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        ptr_valid = 1'b0;
        ptr_index = 8'h00;
        ptr_word  = 16'h0000;
    end

    // pairs always run to 191; in sdh mode the tail carries junk that must be ignored
    task automatic send_frame(input logic [15:0] w, input logic sdh, input logic bad);
        logic [15:0] ci;
        for (int i = 0; i < 192; i++) begin
            @(negedge clk_sys);
            ci = i[0] ? spi_pkg::AIS_WORD : {spi_pkg::NORMAL_STATE_FLAG, sdh ? spi_pkg::SDH_SS : 2'h1, spi_pkg::CI_VALUE};
            if (bad && i == 5) ci = 16'h6bfe;
            if (sdh && i > 63) ci = ~ptr_word;
            ptr_valid = 1'b1;
            ptr_index = 8'(i);
            ptr_word  = (i == 0) ? w : ci;
        end
        @(negedge clk_sys);
        // released lines are inverted once so a stale word is never mistaken for a live one
        ptr_valid = 1'b0;
        ptr_index = ~ptr_index;
        ptr_word  = ~ptr_word;
    endtask : send_frame
endmodule : spi_line_src
`default_nettype wire

// ### testbench/spi_pointer_interp_tb.sv
// self-checking bench for the receive pointer interpreter
`default_nettype none
module spi_pointer_interp_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [2:0] S_N = 3'(spi_pkg::ST_NORMAL_STATE);
    localparam logic [2:0] S_L = 3'(spi_pkg::ST_LOP);
    localparam logic [2:0] S_A = 3'(spi_pkg::ST_AIS);
    logic        clk_sys = 1'b0;
    logic        reset   = 1'b1;
    logic        sdh_mode = 1'b0;
    logic        ptr_valid;
    logic [7:0]  ptr_index;
    logic [15:0] ptr_word;
    logic        alarm_flag_read = 1'b0;
    logic        pending_read = 1'b0;
    logic        ais_ma = 1'b0;
    logic        ais_mb = 1'b1;
    logic        lop_ma = 1'b1;
    logic        lop_mb = 1'b0;
    logic [9:0]  pointer_value;
    logic        normal_state, pointer_loss_state, alarm_state, pointer_update;
    logic        path_alarm_indication_flag, path_pointer_loss_flag;
    logic        path_alarm_indication_pending, path_pointer_loss_pending;
    logic        interrupt_out_a, interrupt_out_b;
    logic [12:0] exp_q[$];
    logic [12:0] exp_e;
    logic [15:0] got;
    logic [31:0] rnd = 32'hbf25;
    logic [9:0]  v;
    int          fails = 0;
    int          n_compared = 0;
    int          cycles = 0;

    spi_line_src i_spi_line_src (.clk_sys(clk_sys), .ptr_valid(ptr_valid), .ptr_index(ptr_index), .ptr_word(ptr_word));

    spi_pointer_interp i_spi_pointer_interp (
        .clk_sys(clk_sys), .reset(reset), .sdh_mode(sdh_mode), .ptr_valid(ptr_valid), .ptr_index(ptr_index),
        .ptr_word(ptr_word), .alarm_flag_read(alarm_flag_read), .pending_read(pending_read),
        .alarm_indication_irq_a_mask(ais_ma), .alarm_indication_irq_b_mask(ais_mb),
        .pointer_loss_irq_a_mask(lop_ma), .pointer_loss_irq_b_mask(lop_mb),
        .pointer_value(pointer_value), .normal_state(normal_state), .pointer_loss_state(pointer_loss_state),
        .alarm_state(alarm_state), .pointer_update(pointer_update),
        .path_alarm_indication_flag(path_alarm_indication_flag), .path_pointer_loss_flag(path_pointer_loss_flag),
        .path_alarm_indication_pending(path_alarm_indication_pending),
        .path_pointer_loss_pending(path_pointer_loss_pending),
        .interrupt_out_a(interrupt_out_a), .interrupt_out_b(interrupt_out_b));

    initial begin
        forever #20 clk_sys = ~clk_sys;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    // normal-flag word with the ss field the current mode expects (01 in sonet, ignored there)
    function automatic logic [15:0] nw(input logic [9:0] val);
        return {spi_pkg::NORMAL_STATE_FLAG, sdh_mode ? spi_pkg::SDH_SS : 2'h1, val};
    endfunction : nw

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk

    task automatic summarize();
        if (fails == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : summarize

    task automatic frame(input logic [15:0] w, input logic [2:0] st, input logic [9:0] val, input logic bad);
        exp_q.push_back({st, val});
        i_spi_line_src.send_frame(w, sdh_mode, bad);
        repeat (2) @(negedge clk_sys);
    endtask : frame

    task automatic rd(input logic fl, input logic pn);
        @(negedge clk_sys);
        alarm_flag_read = fl;
        pending_read    = pn;
        @(negedge clk_sys);
        alarm_flag_read = 1'b0;
        pending_read    = 1'b0;
        @(negedge clk_sys);
    endtask : rd

    // value only matters while a pointer is held in the normal state
    always @(negedge clk_sys) begin
        if (pointer_update === 1'b1) begin
            exp_e = (exp_q.size() != 0) ? exp_q.pop_front() : 13'h1fff;
            got = {3'h0, alarm_state, pointer_loss_state, normal_state,
                   (exp_e[12:10] == S_N) ? pointer_value : exp_e[9:0]};
            chk(got, {3'h0, exp_e});
        end
    end

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 25000) begin
            fails++;
            summarize();
        end
    end

    initial begin
        repeat (8) @(negedge clk_sys);
        reset = 1'b0;
        chk(16'({alarm_state, pointer_loss_state, normal_state, path_pointer_loss_flag, interrupt_out_a}), 16'h08);
        frame(nw(10'h064), S_L, 10'h000, 1'b0);
        frame({4'h7, 2'h1, 10'h064}, S_L, 10'h000, 1'b0);
        frame(nw(10'h064), S_N, 10'h064, 1'b0);
        chk(16'({path_pointer_loss_flag, path_pointer_loss_pending, interrupt_out_a, interrupt_out_b}), 16'he);
        rd(1'b1, 1'b1);
        chk(16'({path_pointer_loss_flag, path_pointer_loss_pending, interrupt_out_a}), 16'h0);
        frame(nw(10'h064 ^ spi_pkg::I_MASK ^ 10'h007), S_N, 10'h064, 1'b0);
        frame(nw(10'h064 ^ spi_pkg::I_MASK), S_N, 10'h065, 1'b0);
        frame(nw(10'h065 ^ spi_pkg::D_MASK), S_N, 10'h065, 1'b0);
        repeat (2) frame(nw(10'h065), S_N, 10'h065, 1'b0);
        frame(nw(10'h065 ^ spi_pkg::D_MASK ^ 10'h003), S_N, 10'h064, 1'b0);
        rnd = lfsr(rnd);
        v = 10'(rnd % 783);
        frame({4'hb, 2'h1, v}, S_N, v, 1'b0);
        for (int i = 0; i < 13; i++) begin
            frame((i == 4 || i == 2) ? nw(v) : nw(10'h30f), (i == 12) ? S_L : S_N, v, i == 2);
        end
        chk(16'({path_pointer_loss_flag, path_pointer_loss_pending, interrupt_out_a}), 16'h7);
        for (int i = 0; i < 3; i++) begin
            frame(spi_pkg::AIS_WORD, (i == 2) ? S_A : S_L, 10'h000, 1'b0);
        end
        chk(16'({path_alarm_indication_flag, path_alarm_indication_pending, interrupt_out_b}), 16'h7);
        chk(16'({interrupt_out_a, interrupt_out_b}), 16'h3);
        @(negedge clk_sys);
        ais_ma = 1'b0;
        ais_mb = 1'b0;
        lop_ma = 1'b0;
        lop_mb = 1'b1;
        @(negedge clk_sys);
        chk(16'({interrupt_out_a, interrupt_out_b}), 16'h1);
        rd(1'b1, 1'b1);
        chk(16'({path_alarm_indication_flag, path_pointer_loss_flag, path_alarm_indication_pending,
                 path_pointer_loss_pending, interrupt_out_a, interrupt_out_b}), 16'h20);
        for (int i = 0; i < 3; i++) begin
            frame(nw(10'h30e), (i == 2) ? S_N : S_A, 10'h30e, 1'b0);
        end
        @(negedge clk_sys);
        sdh_mode = 1'b1;
        frame(nw(10'h30e), S_N, 10'h30e, 1'b0);
        repeat (3) frame({4'h6, 2'h0, 10'h00a}, S_N, 10'h30e, 1'b0);
        frame(nw(10'h30e ^ 10'h2a5), S_N, 10'h000, 1'b0);
        repeat (3) frame(nw(10'h000), S_N, 10'h000, 1'b0);
        frame(nw(10'h2b5), S_N, 10'h000, 1'b0);
        frame(nw(10'h0b5), S_N, 10'h30e, 1'b0);
        repeat (4) @(negedge clk_sys);
        chk(16'(exp_q.size()), 16'h0);
        summarize();
    end
endmodule : spi_pointer_interp_tb
`default_nettype wire
